// ### rtl/tw_target.sv
`timescale 1ns/10ps
`default_nettype none
`include "tw_cfg.svh"
module tw_target
  import tw_pkg::*;
#(
  parameter int WR_CYCLES = `TW_T_WR_CYCLES
)(
  input wire logic clk,
  input wire logic rstn,
  tw_if.dev link,
  input wire logic device_select_hi_pin,
  input wire logic device_select_lo_pin,
  input wire logic write_protect_pin,
  output logic write_busy
);
  logic [4:0] s1_reg;
  logic [4:0] s1_next;
  logic [4:0] s2_reg;
  logic [4:0] s2_next;
  logic sda_d_reg;
  logic sda_d_next;
  logic scl_q;
  logic sda_q;
  logic hi_q;
  logic lo_q;
  logic wp_q;
  logic start_ev;
  logic stop_ev;
  logic frame_reg;
  logic frame_next;
  logic [2:0] hold_reg;
  logic [2:0] hold_next;
  logic lrst_n_reg;
  logic lrst_n_next;
  logic link_rst_n;
  tw_cstate_type cstate_reg;
  tw_cstate_type cstate_next;
  logic [`TW_PAGE_W-1:0] idx_reg;
  logic [`TW_PAGE_W-1:0] idx_next;
  logic [`TW_TIMER_W-1:0] timer_reg;
  logic [`TW_TIMER_W-1:0] timer_next;
  logic mem_we;
  logic [`TW_ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] mem_arr [0:(1 << `TW_ADDR_W)-1];
  logic [7:0] pbuf [0:`TW_PAGE_BYTES-1];
  tw_dstate_type st_reg;
  tw_dstate_type st_next;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic [6:0] sh_reg;
  logic [6:0] sh_next;
  logic ack_reg;
  logic ack_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [`TW_PAGE_BYTES-1:0] pvalid_reg;
  logic [`TW_PAGE_BYTES-1:0] pvalid_next;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [`TW_ADDR_W-1:0] addr_reg;
  logic [`TW_ADDR_W-1:0] addr_next;
  logic pb_we;
  logic [7:0] byte_in;
  logic oe_reg;
  logic oe_next;

  // pins pass two flops before the clk-side logic; the link side takes scl and sda straight from the pins
  always_comb begin
    s1_next = {link.scl, link.sda, device_select_hi_pin, device_select_lo_pin, write_protect_pin};
    s2_next = s1_reg;
    sda_d_next = s2_reg[3];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= `TW_SYNC_RST;
      s2_reg <= `TW_SYNC_RST;
      sda_d_reg <= 1'h1;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      sda_d_reg <= sda_d_next;
    end
  end

  assign scl_q = s2_reg[4];
  assign sda_q = s2_reg[3];
  assign hi_q = s2_reg[2];
  assign lo_q = s2_reg[1];
  assign wp_q = s2_reg[0];
  assign start_ev = scl_q & sda_d_reg & ~sda_q;
  assign stop_ev = scl_q & ~sda_d_reg & sda_q;
  assign write_busy = (cstate_reg != CS_IDLE);
  // short pulse clears the link logic; scl is high, so no edge races it
  assign link_rst_n = rstn & lrst_n_reg;

  always_comb begin
    frame_next = frame_reg;
    hold_next = hold_reg;
    cstate_next = cstate_reg;
    idx_next = idx_reg;
    timer_next = timer_reg;
    mem_we = 1'h0;
    mem_wa = {addr_reg[`TW_ADDR_W-1:`TW_PAGE_W], idx_reg};
    mem_wd = pbuf[idx_reg];
    if (hold_reg != 3'h0) begin
      hold_next = hold_reg - 3'h1;
    end
    lrst_n_next = (hold_next == 3'h0);
    if (stop_ev) begin
      frame_next = 1'h0;
    end
    // poll gets no ack until idle
    if (start_ev) begin
      frame_next = (cstate_reg == CS_IDLE);
      if (cstate_reg == CS_IDLE) begin
        hold_next = `TW_START_HOLD;
        lrst_n_next = 1'h0;
      end
    end
    unique case (cstate_reg)
      CS_IDLE: begin
        if (stop_ev && frame_reg && wr_pend_reg && !wp_q) begin
          cstate_next = CS_COPY;
          idx_next = '0;
        end
      end
      CS_COPY: begin
        mem_we = pvalid_reg[idx_reg];
        idx_next = idx_reg + 6'h01;
        if (idx_reg == 6'h3F) begin
          cstate_next = CS_WAIT;
          timer_next = `TW_TIMER_W'(WR_CYCLES - `TW_PAGE_BYTES - 1);
        end
      end
      CS_WAIT: begin
        timer_next = timer_reg - 1'h1;
        if (timer_reg == '0) begin
          cstate_next = CS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frame_reg <= 1'h0;
      hold_reg <= 3'h0;
      lrst_n_reg <= 1'h1;
      cstate_reg <= CS_IDLE;
      idx_reg <= '0;
      timer_reg <= '0;
    end else begin
      frame_reg <= frame_next;
      hold_reg <= hold_next;
      lrst_n_reg <= lrst_n_next;
      cstate_reg <= cstate_next;
      idx_reg <= idx_next;
      timer_reg <= timer_next;
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_arr[mem_wa] <= mem_wd;
    end
  end

  // link side: frame_reg, straps and array are quiet around scl edges
  assign byte_in = {sh_reg, link.sda};

  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    ack_next = ack_reg;
    tx_next = tx_reg;
    pvalid_next = pvalid_reg;
    wr_pend_next = wr_pend_reg;
    addr_next = addr_reg;
    pb_we = 1'h0;
    if (frame_reg) begin
      if (bit_reg != `TW_WORD_BITS) begin
        sh_next = byte_in[6:0];
        bit_next = bit_reg + 4'h1;
        if (bit_reg == 4'h7) begin
          ack_next = 1'h1;
          unique case (st_reg)
            DS_DEV: begin
              if (byte_in[7:1] == {`TW_DEV_PREFIX, hi_q, lo_q}) begin
                st_next = byte_in[0] ? DS_RDAT : DS_ADH;
              end else begin
                ack_next = 1'h0;
                st_next = DS_IDLE;
              end
            end
            DS_ADH: begin
              addr_next = {byte_in[6:0], addr_reg[7:0]};
              st_next = DS_ADL;
            end
            DS_ADL: begin
              addr_next = {addr_reg[`TW_ADDR_W-1:8], byte_in};
              st_next = DS_WDAT;
            end
            DS_WDAT: begin
              pb_we = 1'h1;
              pvalid_next[addr_reg[`TW_PAGE_W-1:0]] = 1'h1;
              wr_pend_next = 1'h1;
              addr_next[`TW_PAGE_W-1:0] = addr_reg[`TW_PAGE_W-1:0] + 6'h01;
            end
            DS_RDAT, DS_IDLE: begin
              ack_next = 1'h0;
            end
          endcase
        end
      end else begin
        bit_next = 4'h0;
        ack_next = 1'h0;
        if (st_reg == DS_RDAT) begin
          if (ack_reg || !link.sda) begin
            tx_next = mem_arr[addr_reg];
            addr_next = addr_reg + 15'h0001;
          end else begin
            st_next = DS_IDLE;
          end
        end
      end
    end
  end

  always_ff @(posedge link.scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      st_reg <= DS_DEV;
      bit_reg <= 4'h0;
      sh_reg <= 7'h00;
      ack_reg <= 1'h0;
      tx_reg <= 8'hFF;
      pvalid_reg <= '0;
      wr_pend_reg <= 1'h0;
    end else begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      ack_reg <= ack_next;
      tx_reg <= tx_next;
      pvalid_reg <= pvalid_next;
      wr_pend_reg <= wr_pend_next;
    end
  end

  // counter survives frames; only power-on reset clears it
  always_ff @(posedge link.scl or negedge rstn) begin
    if (!rstn) begin
      addr_reg <= '0;
    end else begin
      addr_reg <= addr_next;
    end
  end

  always_ff @(posedge link.scl) begin
    if (pb_we) begin
      pbuf[addr_reg[`TW_PAGE_W-1:0]] <= byte_in;
    end
  end

  always_comb begin
    oe_next = 1'h0;
    if (frame_reg) begin
      if (bit_reg == `TW_WORD_BITS) begin
        oe_next = ack_reg;
      end else if (st_reg == DS_RDAT) begin
        oe_next = ~tx_reg[~bit_reg[2:0]];
      end
    end
  end

  always_ff @(negedge link.scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      oe_reg <= 1'h0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  assign link.dev_sda_oe = oe_reg & frame_reg;
  assign link.dev_sda_o = 1'h0;
endmodule
`default_nettype wire

// ### rtl/tw_cfg.svh
`ifndef TW_CFG_SVH
`define TW_CFG_SVH
// device address word: fixed prefix 10100, two strap bits, read bit
`define TW_DEV_PREFIX 5'h14
`define TW_ADDR_W 15
`define TW_PAGE_W 6
`define TW_PAGE_BYTES 64
`define TW_WORD_BITS 4'h8
`define TW_CLK_PERIOD_NS 4
// self-timed write, longest time of the faster supply grades
`define TW_T_WR_MS 10
`define TW_T_WR_CYCLES (`TW_T_WR_MS * 1000000 / `TW_CLK_PERIOD_NS)
`define TW_TIMER_W 24
// link reset pulse after an accepted start
`define TW_START_HOLD 3'h4
// controller: one quarter of a serial clock period
`define TW_T_QTR_NS 700
`define TW_QTR_CYCLES (`TW_T_QTR_NS / `TW_CLK_PERIOD_NS)
`define TW_QTR_W 16
`define TW_RECOV_LAST 4'h8
`define TW_SYNC_RST 5'h18
`endif

// ### rtl/tw_pkg.sv
package tw_pkg;
  typedef enum logic [5:0] {
    DS_IDLE = 6'h01,
    DS_DEV = 6'h02,
    DS_ADH = 6'h04,
    DS_ADL = 6'h08,
    DS_WDAT = 6'h10,
    DS_RDAT = 6'h20
  } tw_dstate_type;
  typedef enum logic [2:0] {
    CS_IDLE = 3'h1,
    CS_COPY = 3'h2,
    CS_WAIT = 3'h4
  } tw_cstate_type;
  typedef enum logic [4:0] {
    HS_IDLE = 5'h01,
    HS_START = 5'h02,
    HS_STOP = 5'h04,
    HS_BIT = 5'h08,
    HS_RECOV = 5'h10
  } tw_hstate_type;
  typedef enum logic [2:0] {
    OP_START = 3'h0,
    OP_STOP = 3'h1,
    OP_WRITE = 3'h2,
    OP_READ_ACK = 3'h3,
    OP_READ_NACK = 3'h4,
    OP_RECOVER = 3'h5
  } tw_op_type;
endpackage

// ### rtl/tw_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tw_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // open-drain wire with pull-up
  assign sda = (host_sda_oe ? host_sda_o : 1'h1) & (dev_sda_oe ? dev_sda_o : 1'h1);
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

// ### rtl/tw_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "tw_cfg.svh"
module tw_ctrl
  import tw_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  tw_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire tw_op_type cmd_op,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);
  tw_hstate_type hs_reg;
  tw_hstate_type hs_next;
  tw_op_type op_reg;
  tw_op_type op_next;
  logic [`TW_QTR_W-1:0] div_reg;
  logic [`TW_QTR_W-1:0] div_next;
  logic [1:0] ph_reg;
  logic [1:0] ph_next;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic scl_reg;
  logic scl_next;
  logic oe_reg;
  logic oe_next;
  logic rv_reg;
  logic rv_next;
  logic [7:0] rd_reg;
  logic [7:0] rd_next;
  logic ra_reg;
  logic ra_next;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic tick;

  assign tick = (div_reg == '0);
  assign cmd_ready = (hs_reg == HS_IDLE);

  always_comb begin
    hs_next = hs_reg;
    op_next = op_reg;
    div_next = tick ? `TW_QTR_W'(`TW_QTR_CYCLES - 1) : div_reg - 1'h1;
    ph_next = tick ? ph_reg + 2'h1 : ph_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    scl_next = scl_reg;
    oe_next = oe_reg;
    rv_next = 1'h0;
    rd_next = rd_reg;
    ra_next = ra_reg;
    unique case (hs_reg)
      HS_IDLE: begin
        ph_next = 2'h0;
        if (cmd_valid) begin
          op_next = cmd_op;
          bit_next = 4'h0;
          div_next = `TW_QTR_W'(`TW_QTR_CYCLES - 1);
          sh_next = (cmd_op == OP_WRITE) ? cmd_data : 8'hFF;
          unique case (cmd_op)
            OP_START: hs_next = HS_START;
            OP_STOP: hs_next = HS_STOP;
            OP_RECOVER: hs_next = HS_RECOV;
            default: hs_next = HS_BIT;
          endcase
        end
      end
      HS_START: begin
        // data falls while clock is high
        if (tick) begin
          unique case (ph_reg)
            2'h0: oe_next = 1'h0;
            2'h1: scl_next = 1'h1;
            2'h2: oe_next = 1'h1;
            2'h3: begin
              scl_next = 1'h0;
              hs_next = HS_IDLE;
              rv_next = 1'h1;
              ra_next = 1'h1;
            end
          endcase
        end
      end
      HS_STOP: begin
        // data rises while clock is high; bus is left idle high
        if (tick) begin
          unique case (ph_reg)
            2'h0: oe_next = 1'h1;
            2'h1: scl_next = 1'h1;
            2'h2: oe_next = 1'h0;
            2'h3: begin
              hs_next = HS_IDLE;
              rv_next = 1'h1;
              ra_next = 1'h1;
            end
          endcase
        end
      end
      HS_BIT: begin
        if (tick) begin
          unique case (ph_reg)
            2'h0: oe_next = (bit_reg == `TW_WORD_BITS) ? (op_reg == OP_READ_ACK) : ~sh_reg[7];
            2'h1: scl_next = 1'h1;
            2'h2: begin
              if (bit_reg == `TW_WORD_BITS) begin
                ra_next = ~sda_s2_reg;
              end else begin
                sh_next = {sh_reg[6:0], sda_s2_reg};
              end
            end
            2'h3: begin
              scl_next = 1'h0;
              bit_next = bit_reg + 4'h1;
              if (bit_reg == `TW_WORD_BITS) begin
                hs_next = HS_IDLE;
                rv_next = 1'h1;
                rd_next = sh_reg;
                oe_next = 1'h0;
              end
            end
          endcase
        end
      end
      HS_RECOV: begin
        // up to nine clocks, stopping once data reads high, then start
        // start restarts at its first quarter, else it would drop scl without a data fall
        if (tick) begin
          unique case (ph_reg)
            2'h0: oe_next = 1'h0;
            2'h1: scl_next = 1'h1;
            2'h2: begin
              if (sda_s2_reg) begin
                hs_next = HS_START;
                ph_next = 2'h0;
              end
            end
            2'h3: begin
              scl_next = 1'h0;
              bit_next = bit_reg + 4'h1;
              if (bit_reg == `TW_RECOV_LAST) begin
                hs_next = HS_START;
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hs_reg <= HS_IDLE;
      op_reg <= OP_START;
      div_reg <= '0;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'hFF;
      scl_reg <= 1'h1;
      oe_reg <= 1'h0;
      rv_reg <= 1'h0;
      rd_reg <= 8'h00;
      ra_reg <= 1'h0;
      sda_s1_reg <= 1'h1;
      sda_s2_reg <= 1'h1;
    end else begin
      hs_reg <= hs_next;
      op_reg <= op_next;
      div_reg <= div_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      scl_reg <= scl_next;
      oe_reg <= oe_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      ra_reg <= ra_next;
      sda_s1_reg <= link.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  assign link.scl = scl_reg;
  assign link.host_sda_oe = oe_reg;
  assign link.host_sda_o = 1'h0;
  assign rsp_valid = rv_reg;
  assign rsp_data = rd_reg;
  assign rsp_ack = ra_reg;
endmodule
`default_nettype wire

// ### dv/tw_chk.sv
`timescale 1ns/10ps
`default_nettype none
module tw_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic scl_reg, sda_reg, frame_reg, first_reg, rw_reg;
  logic frame_next, first_next, rw_next, start_w, rise_w;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // bit count is only trusted with the clock high two samples in a row
  always_comb begin
    start_w = scl && scl_reg && sda_reg && !sda;
    rise_w = scl && !scl_reg;
    frame_next = frame_reg;
    first_next = first_reg;
    rw_next = rw_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    if (start_w) begin
      frame_next = 1'h1;
      first_next = 1'h1;
      cnt_next = 4'h0;
    end else if (scl && scl_reg && !sda_reg && sda) begin
      frame_next = 1'h0;
    end else if (rise_w) begin
      cnt_next = (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
      if (cnt_reg == 4'h9) begin
        first_next = 1'h0;
      end
      if (cnt_reg < 4'h8) begin
        sh_next = {sh_reg[6:0], sda};
      end
      if (first_reg && cnt_reg == 4'h7) begin
        rw_next = sda;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_reg <= 1'h1;
      sda_reg <= 1'h1;
      frame_reg <= 1'h0;
      first_reg <= 1'h0;
      rw_reg <= 1'h0;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      frame_reg <= frame_next;
      first_reg <= first_next;
      rw_reg <= rw_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
    end
  end
  a_dev_drive_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target data moved while clock high");
  a_idle_quiet: assert property (!frame_reg |-> !dev_sda_oe)
    else $error("target drives data outside a frame");
  a_idle_clock_high: assert property (!frame_reg |-> scl)
    else $error("clock low between frames");
  a_clock_high_min: assert property ($rose(scl) |=> scl [*8])
    else $error("clock high phase too short");
  a_start_hold: assert property (start_w |=> scl [*8])
    else $error("clock fell too soon after start");
  a_ack_slot_only: assert property (scl && scl_reg && dev_sda_oe |-> (cnt_reg == 4'h9) == (first_reg || !rw_reg))
    else $error("target drove data outside its slots");
  a_prefix_ack: assert property (scl && scl_reg && first_reg && cnt_reg == 4'h9 && dev_sda_oe |-> sh_reg[7:3] == 5'h14)
    else $error("address acked without prefix");
  a_host_yield_ack: assert property (scl && scl_reg && cnt_reg == 4'h9 && (first_reg || !rw_reg) |-> !host_sda_oe)
    else $error("controller drove the acknowledge slot");
  a_open_drain_low: assert property (!host_sda_o && !dev_sda_o)
    else $error("data driver not open drain");
  c_addr_ack: cover property (scl && scl_reg && first_reg && cnt_reg == 4'h9 && dev_sda_oe);
  c_read_bit: cover property (rw_reg && !first_reg && dev_sda_oe);
  c_restart: cover property (start_w && frame_reg);
endmodule
`default_nettype wire

// ### dv/two_wire_eeprom_target_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module two_wire_eeprom_target_tb_top
  import tw_pkg::*;
();
  logic clk = 1'h0;
  logic rstn, cmd_valid, cmd_ready, rsp_valid, rsp_ack, write_busy;
  tw_op_type cmd_op;
  logic [7:0] cmd_data, rsp_data;
  int bad_count = 0;
  int compares = 0;
  tw_if link ();
  tw_ctrl i_tw_ctrl (.clk(clk), .rstn(rstn), .link(link.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  // short write cycle, still long enough to cover the poll start
  tw_target #(.WR_CYCLES(3000)) i_tw_target (.clk(clk), .rstn(rstn), .link(link.dev),
    .device_select_hi_pin(1'h1), .device_select_lo_pin(1'h0), .write_protect_pin(1'h0), .write_busy(write_busy));
  tw_chk i_tw_chk (.clk(clk), .rstn(rstn), .scl(link.scl), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));
  always #2 clk = ~clk;
  task automatic results();
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one command, raised for one cycle once ready, then wait for its answer
  task automatic do_op(input tw_op_type op, input logic [7:0] data);
    int n;
    @(negedge clk);
    for (n = 0; n < 20000 && cmd_ready !== 1'h1; n++) @(negedge clk);
    cmd_op = op;
    cmd_data = data;
    cmd_valid = 1'h1;
    @(negedge clk);
    cmd_valid = 1'h0;
    for (n = 0; n < 20000 && rsp_valid !== 1'h1; n++) @(negedge clk);
    if (n >= 20000) begin
      bad_count++;
      $display("FAIL %0t no answer", $time);
      results();
    end
  endtask
  task automatic wr(input logic [7:0] b, input logic ack);
    do_op(OP_WRITE, b);
    check_bit(rsp_ack, ack, "byte acknowledge");
  endtask
  initial begin
    rstn = 1'h0;
    cmd_valid = 1'h0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rstn = 1'h1;
    repeat (3) @(negedge clk);
    // page write running past the page end
    do_op(OP_START, 8'h00);
    wr(8'hA4, 1'h1);
    wr(8'h00, 1'h1);
    wr(8'h3F, 1'h1);
    wr(8'h5A, 1'h1);
    wr(8'hC3, 1'h1);
    do_op(OP_STOP, 8'h00);
    check_bit(write_busy, 1'h1, "write cycle running");
    $display("test page_write done");
    // poll while busy, then random read of the wrapped byte
    do_op(OP_START, 8'h00);
    wr(8'hA4, 1'h0);
    do_op(OP_START, 8'h00);
    wr(8'hA4, 1'h1);
    wr(8'h00, 1'h1);
    wr(8'h00, 1'h1);
    do_op(OP_START, 8'h00);
    wr(8'hA5, 1'h1);
    do_op(OP_READ_NACK, 8'h00);
    check_byte(rsp_data, 8'hC3, "wrapped byte");
    do_op(OP_STOP, 8'h00);
    check_bit(write_busy, 1'h0, "no write after read");
    $display("test poll_read done");
    // strap mismatch, then recovery and a fresh address
    do_op(OP_START, 8'h00);
    wr(8'hA6, 1'h0);
    do_op(OP_STOP, 8'h00);
    do_op(OP_RECOVER, 8'h00);
    wr(8'hA4, 1'h1);
    do_op(OP_STOP, 8'h00);
    check_bit(write_busy, 1'h0, "no write after address only");
    $display("test mismatch_recover done");
    results();
  end
endmodule
`default_nettype wire
